// ===== rtl/waveform_gen_steering_select.sv
// Purpose: register file, input select, steering and shutdown outputs
// Assumes: APB slave, zero-wait access phase, pclk at 50 MHz
// Notes:   dead-band counts are stored only; timing lives elsewhere
`timescale 1ns/1ps
`default_nettype none
module waveform_gen_steering_select (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic [12:0] wave_sources,
	input  wire logic        logic_cell2_output,
	input  wire logic        comparator2_out,
	input  wire logic        comparator1_out,
	input  wire logic        timer2_postscale_out,
	input  wire logic        shutdown_pin_remap,
	output var  logic [3:0]  waveform_out,
	output var  logic [3:0]  waveform_oe_n,
	output var  logic        irq
);
	// Register fields
	logic        enable_ff;
	logic        load_ff;
	logic [2:0]  mode_ff;
	logic [3:0]  polarity_ff;
	logic [5:0]  rise_db_ff;
	logic [5:0]  fall_db_ff;
	logic        shut_status_ff;
	logic        restart_en_ff;
	logic [1:0]  pair_bd_shutdown_state;
	logic [1:0]  pair_ac_shutdown_state;
	logic [4:0]  shut_source_ff;
	logic [7:0]  steer_ff;
	logic        osc_select_ff;
	logic [3:0]  waveform_input_code;
	logic [1:0]  irq_status_ff;
	logic [1:0]  irq_mask_ff;
	// Generator state
	logic [3:0]  steer_active_ff;
	logic        module_clock_signal;
	logic        input_prev_ff;
	logic        shut_hold_ff;
	logic        push_phase_ff;
	logic        status_prev_ff;
	// Combinational
	logic [12:0] wave_sync;
	logic [4:0]  shut_sync;
	logic        gen_tick;
	logic        generated_waveform;
	logic        input_rise;
	logic        input_fall;
	logic        source_active;
	logic        steering_mode;
	logic        wr_access;
	logic        rd_access;
	logic        setup_phase;
	logic [7:0]  rd_byte;
	logic        rd_hit;
	logic [3:0]  raw_wave;
	logic [3:0]  nxt_out;
	logic [3:0]  nxt_oe_n;

	// Any access phase ends at the edge after setup
	assign setup_phase = psel & ~penable;
	assign wr_access   = psel & penable & pready & pwrite;
	assign rd_access   = psel & penable & pready & ~pwrite;

	// True when an offset is a mapped register
	function automatic logic addr_mapped(input logic [7:0] a);
		logic hit;
		hit = 1'b0;
		if (a == cwg_pkg::ENABLE_MODE_OFFSET) begin
			hit = 1'b1;
		end else if (a == cwg_pkg::POLARITY_OFFSET) begin
			hit = 1'b1;
		end else if (a == cwg_pkg::RISE_DB_OFFSET) begin
			hit = 1'b1;
		end else if (a == cwg_pkg::FALL_DB_OFFSET) begin
			hit = 1'b1;
		end else if (a == cwg_pkg::SHUT_STATE_OFFSET) begin
			hit = 1'b1;
		end else if (a == cwg_pkg::SHUT_SOURCE_OFFSET) begin
			hit = 1'b1;
		end else if (a == cwg_pkg::STEER_OFFSET) begin
			hit = 1'b1;
		end else if (a == cwg_pkg::CLK_SELECT_OFFSET) begin
			hit = 1'b1;
		end else if (a == cwg_pkg::INPUT_SELECT_OFFSET) begin
			hit = 1'b1;
		end else if (a == cwg_pkg::IRQ_STATUS_OFFSET) begin
			hit = 1'b1;
		end else if (a == cwg_pkg::IRQ_MASK_OFFSET) begin
			hit = 1'b1;
		end
		return hit;
	endfunction

	// Waveform input multiplexer
	function automatic logic select_wave(input logic [3:0] code,
			input logic [12:0] srcs, input logic mclk);
		logic v;
		v = 1'b0;
		if (code == 4'h0) begin
			v = mclk;
		end else if (code <= 4'hD) begin
			v = srcs[code - 4'h1];
		end else begin
			v = 1'b0;
		end
		return v;
	endfunction

	// Asynchronous sources pass the three-stage filter
	cwg_input_sync #(.WIDTH(13)) u_wave_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (wave_sources),
		.sync_out (wave_sync)
	);

	cwg_input_sync #(.WIDTH(5)) u_shut_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({logic_cell2_output, comparator2_out, comparator1_out,
			timer2_postscale_out, shutdown_pin_remap}),
		.sync_out (shut_sync)
	);

	// Module clock enable from the clock select bit
	cwg_clock_tick u_tick (
		.pclk       (pclk),
		.presetn    (presetn),
		.osc_select (osc_select_ff),
		.tick       (gen_tick)
	);

	// Input selection and edge detection on module ticks
	assign generated_waveform = select_wave(waveform_input_code, wave_sync,
		module_clock_signal);
	assign input_rise = gen_tick & generated_waveform & ~input_prev_ff;
	assign input_fall = gen_tick & ~generated_waveform & input_prev_ff;
	assign source_active = |(shut_source_ff & shut_sync);
	assign steering_mode = (mode_ff[2:1] == 2'b00);

	// Read data selection
	always_comb begin
		rd_byte = 8'h00;
		rd_hit  = addr_mapped(paddr);
		if (paddr == cwg_pkg::ENABLE_MODE_OFFSET) begin
			rd_byte = {enable_ff, load_ff, 3'b000, mode_ff};
		end else if (paddr == cwg_pkg::POLARITY_OFFSET) begin
			rd_byte = {2'b00, input_prev_ff, 1'b0, polarity_ff};
		end else if (paddr == cwg_pkg::RISE_DB_OFFSET) begin
			rd_byte = {2'b00, rise_db_ff};
		end else if (paddr == cwg_pkg::FALL_DB_OFFSET) begin
			rd_byte = {2'b00, fall_db_ff};
		end else if (paddr == cwg_pkg::SHUT_STATE_OFFSET) begin
			rd_byte = {shut_status_ff, restart_en_ff, pair_bd_shutdown_state,
				pair_ac_shutdown_state, 2'b00};
		end else if (paddr == cwg_pkg::SHUT_SOURCE_OFFSET) begin
			rd_byte = {3'b000, shut_source_ff};
		end else if (paddr == cwg_pkg::STEER_OFFSET) begin
			rd_byte = steer_ff;
		end else if (paddr == cwg_pkg::CLK_SELECT_OFFSET) begin
			rd_byte = {7'h00, osc_select_ff};
		end else if (paddr == cwg_pkg::INPUT_SELECT_OFFSET) begin
			rd_byte = {4'h0, waveform_input_code};
		end else if (paddr == cwg_pkg::IRQ_STATUS_OFFSET) begin
			rd_byte = {6'h00, irq_status_ff};
		end else if (paddr == cwg_pkg::IRQ_MASK_OFFSET) begin
			rd_byte = {6'h00, irq_mask_ff};
		end
	end

	// APB answer: registered, one access cycle after setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup_phase;
			pslverr <= setup_phase & ~rd_hit;
			if (setup_phase && !pwrite) begin
				prdata <= {24'h00_0000, rd_byte};
			end else if (setup_phase) begin
				prdata <= 32'h0000_0000;
			end
		end
	end

	// Enable, load and mode fields
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_ff <= cwg_pkg::ENABLE_MODE_RESET[cwg_pkg::ENABLE_BIT];
			load_ff   <= cwg_pkg::ENABLE_MODE_RESET[cwg_pkg::LOAD_BIT];
			mode_ff   <= cwg_pkg::ENABLE_MODE_RESET[2:0];
		end else if (wr_access && paddr == cwg_pkg::ENABLE_MODE_OFFSET) begin
			enable_ff <= pwdata[cwg_pkg::ENABLE_BIT];
			// Load needs the module already on
			load_ff   <= (load_ff & ~(input_rise | input_fall))
				| (pwdata[cwg_pkg::LOAD_BIT] & enable_ff);
			mode_ff   <= pwdata[2:0];
		end else if (input_rise || input_fall) begin
			load_ff   <= 1'b0;
		end
	end

	// Polarity, dead band, clock select and input select
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			polarity_ff         <= cwg_pkg::POLARITY_RESET;
			rise_db_ff          <= cwg_pkg::DEADBAND_RESET;
			fall_db_ff          <= cwg_pkg::DEADBAND_RESET;
			osc_select_ff       <= 1'b0;
			waveform_input_code <= cwg_pkg::INPUT_SEL_RESET;
		end else if (wr_access) begin
			if (paddr == cwg_pkg::POLARITY_OFFSET) begin
				polarity_ff <= pwdata[3:0];
			end else if (paddr == cwg_pkg::RISE_DB_OFFSET) begin
				rise_db_ff <= pwdata[5:0];
			end else if (paddr == cwg_pkg::FALL_DB_OFFSET) begin
				fall_db_ff <= pwdata[5:0];
			end else if (paddr == cwg_pkg::CLK_SELECT_OFFSET) begin
				osc_select_ff <= pwdata[0];
			end else if (paddr == cwg_pkg::INPUT_SELECT_OFFSET) begin
				waveform_input_code <= pwdata[3:0];
			end
		end
	end

	// Shutdown sources and steering register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shut_source_ff <= cwg_pkg::SHUT_SOURCE_RESET;
			steer_ff       <= cwg_pkg::STEER_RESET;
		end else if (wr_access) begin
			if (paddr == cwg_pkg::SHUT_SOURCE_OFFSET) begin
				shut_source_ff <= pwdata[4:0];
			end else if (paddr == cwg_pkg::STEER_OFFSET) begin
				steer_ff <= pwdata[7:0];
			end
		end
	end

	// Shutdown control; a source event beats a software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shut_status_ff         <= 1'b0;
			restart_en_ff          <= 1'b0;
			pair_bd_shutdown_state <= cwg_pkg::PAIR_STATE_RESET;
			pair_ac_shutdown_state <= cwg_pkg::PAIR_STATE_RESET;
		end else begin
			if (wr_access && paddr == cwg_pkg::SHUT_STATE_OFFSET) begin
				restart_en_ff          <= pwdata[cwg_pkg::RESTART_BIT];
				pair_bd_shutdown_state <= pwdata[cwg_pkg::PAIR_BD_LSB +: 2];
				pair_ac_shutdown_state <= pwdata[cwg_pkg::PAIR_AC_LSB +: 2];
			end
			if (source_active) begin
				shut_status_ff <= 1'b1;
			end else if (wr_access && paddr == cwg_pkg::SHUT_STATE_OFFSET) begin
				shut_status_ff <= pwdata[cwg_pkg::STATUS_BIT];
			end else if (restart_en_ff) begin
				shut_status_ff <= 1'b0;
			end
		end
	end

	// Outputs stay shut until a rising edge after the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shut_hold_ff <= 1'b0;
		end else if (shut_status_ff) begin
			shut_hold_ff <= 1'b1;
		end else if (input_rise) begin
			shut_hold_ff <= 1'b0;
		end
	end

	// Module tick state: clock signal, input history, push phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			module_clock_signal <= 1'b0;
			input_prev_ff       <= 1'b0;
			push_phase_ff       <= 1'b0;
		end else if (gen_tick) begin
			module_clock_signal <= ~module_clock_signal;
			input_prev_ff       <= generated_waveform;
			if (input_rise) begin
				push_phase_ff <= ~push_phase_ff;
			end
		end
	end

	// Steering enables: direct, or buffered to the next rising edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			steer_active_ff <= cwg_pkg::STEER_RESET[3:0];
		end else if (mode_ff == cwg_pkg::MODE_SYNC_STEER) begin
			if (input_rise) begin
				steer_active_ff <= steer_ff[3:0];
			end
		end else begin
			steer_active_ff <= steer_ff[3:0];
		end
	end

	// Raw drive pattern per mode, before polarity
	always_comb begin
		raw_wave = 4'h0;
		case (mode_ff)
			cwg_pkg::MODE_STEER, cwg_pkg::MODE_SYNC_STEER: begin
				raw_wave = {4{input_prev_ff}};
			end
			cwg_pkg::MODE_FWD_FULL: begin
				raw_wave = {input_prev_ff, 2'b00, 1'b1};
			end
			cwg_pkg::MODE_REV_FULL: begin
				raw_wave = {1'b0, 1'b1, input_prev_ff, 1'b0};
			end
			cwg_pkg::MODE_HALF: begin
				raw_wave = {~input_prev_ff, input_prev_ff,
					~input_prev_ff, input_prev_ff};
			end
			cwg_pkg::MODE_PUSH_PULL: begin
				raw_wave = {input_prev_ff & ~push_phase_ff,
					input_prev_ff & push_phase_ff,
					input_prev_ff & ~push_phase_ff,
					input_prev_ff & push_phase_ff};
			end
			default: begin
				raw_wave = 4'h0;
			end
		endcase
	end

	// Output selection: shutdown, disable, steering, waveform
	always_comb begin
		logic [1:0] pair_state;
		pair_state = 2'b00;
		nxt_out    = 4'h0;
		nxt_oe_n   = 4'h0;
		for (int i = 0; i < 4; i++) begin
			// A and C use one field, B and D the other
			pair_state = (i % 2 == 0) ? pair_ac_shutdown_state
				: pair_bd_shutdown_state;
			if (shut_status_ff || shut_hold_ff) begin
				if (pair_state == cwg_pkg::SHUT_DRIVE_ONE) begin
					nxt_out[i] = 1'b1;
				end else if (pair_state == cwg_pkg::SHUT_DRIVE_ZERO) begin
					nxt_out[i] = 1'b0;
				end else if (pair_state == cwg_pkg::SHUT_TRISTATE) begin
					nxt_oe_n[i] = 1'b1;
				end else begin
					nxt_out[i] = polarity_ff[i];
				end
			end else if (!enable_ff) begin
				nxt_out[i] = polarity_ff[i];
			end else if (steering_mode) begin
				nxt_out[i] = steer_active_ff[i]
					? (raw_wave[i] ^ polarity_ff[i])
					: steer_ff[cwg_pkg::OVERRIDE_LSB + i];
			end else begin
				nxt_out[i] = raw_wave[i] ^ polarity_ff[i];
			end
		end
	end

	// Pins are registered so they never glitch on decode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			waveform_out  <= 4'h0;
			waveform_oe_n <= 4'h0;
		end else begin
			waveform_out  <= nxt_out;
			waveform_oe_n <= nxt_oe_n;
		end
	end

	// Event flags: set wins, read clears only what was returned
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status_ff  <= cwg_pkg::IRQ_RESET;
			status_prev_ff <= 1'b0;
		end else begin
			status_prev_ff <= shut_status_ff;
			for (int j = 0; j < 2; j++) begin
				if (j == cwg_pkg::IRQ_SHUTDOWN && shut_status_ff
					&& !status_prev_ff) begin
					irq_status_ff[j] <= 1'b1;
				end else if (j == cwg_pkg::IRQ_RISE && input_rise) begin
					irq_status_ff[j] <= 1'b1;
				end else if (rd_access && paddr == cwg_pkg::IRQ_STATUS_OFFSET
					&& prdata[j]) begin
					irq_status_ff[j] <= 1'b0;
				end
			end
		end
	end

	// Mask register and the interrupt level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_ff <= cwg_pkg::IRQ_RESET;
			irq         <= 1'b0;
		end else begin
			if (wr_access && paddr == cwg_pkg::IRQ_MASK_OFFSET) begin
				irq_mask_ff <= pwdata[1:0];
			end
			irq <= |(irq_status_ff & irq_mask_ff);
		end
	end
endmodule
`default_nettype wire

// ===== rtl/cwg_pkg.sv
// Purpose: constants shared by the waveform generator configuration block
// Assumes: APB with 32-bit data, byte offsets below, pclk at 50 MHz
// Notes:   register contents sit in the low byte of each word
// How it works
// - Bit 4 lets logic cell 2 shut down
// - Bits 3 and 2 enable comparator shutdown
// - Bits 1 and 0 enable timer/pin shutdown
// - Override data D..A in bits 7..4
// - Steer bit picks waveform or override value
// - Steering applies only in modes 00x
// - Sync steering bits are double-buffered
// - Clock select picks 16 MHz or system
// - Four-bit code selects the waveform input
// - Codes 1110 and 1111 connect nothing
// - Three-bit mode field meanings, two reserved
// - Auto-restart clears status when sources low
// - Shutdown drives each pair per 2-bit field
package cwg_pkg;
	// Register byte offsets
	localparam logic [7:0] ENABLE_MODE_OFFSET  = 8'h00;
	localparam logic [7:0] POLARITY_OFFSET     = 8'h04;
	localparam logic [7:0] RISE_DB_OFFSET      = 8'h08;
	localparam logic [7:0] FALL_DB_OFFSET      = 8'h0C;
	localparam logic [7:0] SHUT_STATE_OFFSET   = 8'h10;
	localparam logic [7:0] SHUT_SOURCE_OFFSET  = 8'h14;
	localparam logic [7:0] STEER_OFFSET        = 8'h18;
	localparam logic [7:0] CLK_SELECT_OFFSET   = 8'h1C;
	localparam logic [7:0] INPUT_SELECT_OFFSET = 8'h20;
	localparam logic [7:0] IRQ_STATUS_OFFSET   = 8'h24;
	localparam logic [7:0] IRQ_MASK_OFFSET     = 8'h28;
	// Field positions
	localparam int ENABLE_BIT      = 7;
	localparam int LOAD_BIT        = 6;
	localparam int INPUT_LEVEL_BIT = 5;
	localparam int STATUS_BIT      = 7;
	localparam int RESTART_BIT     = 6;
	localparam int PAIR_BD_LSB     = 4;
	localparam int PAIR_AC_LSB     = 2;
	localparam int OVERRIDE_LSB    = 4;
	localparam int IRQ_SHUTDOWN    = 0;
	localparam int IRQ_RISE        = 1;
	// Reset values
	localparam logic [7:0] ENABLE_MODE_RESET = 8'h00;
	localparam logic [3:0] POLARITY_RESET    = 4'h0;
	localparam logic [5:0] DEADBAND_RESET    = 6'h00;
	localparam logic [1:0] PAIR_STATE_RESET  = 2'h1;
	localparam logic [4:0] SHUT_SOURCE_RESET = 5'h00;
	localparam logic [7:0] STEER_RESET       = 8'h00;
	localparam logic [3:0] INPUT_SEL_RESET   = 4'h0;
	localparam logic [1:0] IRQ_RESET         = 2'h0;
	// Modes
	typedef enum logic [2:0] {
		MODE_STEER, MODE_SYNC_STEER, MODE_FWD_FULL,
		MODE_REV_FULL, MODE_HALF, MODE_PUSH_PULL,
		MODE_RSVD6, MODE_RSVD7
	} mode_e;
	// Shutdown pair states
	localparam logic [1:0] SHUT_DRIVE_ONE  = 2'h3;
	localparam logic [1:0] SHUT_DRIVE_ZERO = 2'h2;
	localparam logic [1:0] SHUT_TRISTATE   = 2'h1;
	// Oscillator tick timing, figures in kHz
	localparam int          PCLK_KHZ = 50000;
	localparam int          OSC_KHZ  = 16000;
	localparam int          TICK_GCD = 2000;
	localparam logic [6:0]  TICK_INC = 7'(OSC_KHZ / TICK_GCD);
	localparam logic [6:0]  TICK_MOD = 7'(PCLK_KHZ / TICK_GCD);
endpackage

// ===== rtl/cwg_input_sync.sv
// Purpose: three-stage synchroniser for asynchronous inputs
// Assumes: inputs come from outside the pclk domain
// Notes:   output changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module cwg_input_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1_ff;
	logic [WIDTH-1:0] stage2_ff;
	logic [WIDTH-1:0] stage3_ff;

	// Stage one is read only by stage two
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage1_ff <= '0;
			stage2_ff <= '0;
			stage3_ff <= '0;
			sync_out  <= '0;
		end else begin
			stage1_ff <= async_in;
			stage2_ff <= stage1_ff;
			stage3_ff <= stage2_ff;
			// Hold old value while stages disagree
			sync_out  <= (~(stage2_ff ^ stage3_ff) & stage3_ff)
				| ((stage2_ff ^ stage3_ff) & sync_out);
		end
	end
endmodule
`default_nettype wire

// ===== rtl/cwg_clock_tick.sv
// Purpose: module clock enable, system rate or 16 MHz average
// Assumes: single pclk domain at 50 MHz
// Notes:   oscillator rate is a fractional enable, jitter of one cycle
`timescale 1ns/1ps
`default_nettype none
module cwg_clock_tick (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic osc_select,
	output var  logic tick
);
	logic [6:0] acc_ff;
	logic [6:0] nxt_sum;

	assign nxt_sum = acc_ff + cwg_pkg::TICK_INC;

	// Accumulate 8 of 25 per cycle for 16 of 50 MHz
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_ff <= '0;
			tick   <= 1'b0;
		end else if (!osc_select) begin
			acc_ff <= '0;
			tick   <= 1'b1;
		end else if (nxt_sum >= cwg_pkg::TICK_MOD) begin
			acc_ff <= nxt_sum - cwg_pkg::TICK_MOD;
			tick   <= 1'b1;
		end else begin
			acc_ff <= nxt_sum;
			tick   <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ===== bench/steering_select_chk.sv
// Purpose: port-level checks for the steering and select block
// Assumes: one pclk domain, APB answer in the cycle after setup
// Notes:   shadows a few registers from completed writes
`timescale 1ns/1ps
`default_nettype none
module steering_select_chk (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        logic_cell2_output,
	input wire logic        comparator2_out,
	input wire logic        comparator1_out,
	input wire logic        timer2_postscale_out,
	input wire logic        shutdown_pin_remap,
	input wire logic [3:0]  waveform_out,
	input wire logic [3:0]  waveform_oe_n,
	input wire logic        irq
);
	logic       acc;
	logic       src_hit;
	logic [4:0] src_en_ff;
	logic [7:0] steer_ff;
	logic [5:0] shst_ff;
	logic [1:0] mask_ff;
	// Completed transfer and any enabled source that is high
	assign acc = psel && penable && pready;
	assign src_hit = |(src_en_ff & {logic_cell2_output, comparator2_out,
		comparator1_out, timer2_postscale_out, shutdown_pin_remap});
	// Shadows move only at the completing edge, like the real registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_en_ff <= 5'h00;
			steer_ff <= 8'h00;
			shst_ff <= 6'h14;
			mask_ff <= 2'h0;
		end else if (acc && pwrite) begin
			case (paddr)
				cwg_pkg::SHUT_SOURCE_OFFSET: src_en_ff <= pwdata[4:0];
				cwg_pkg::STEER_OFFSET: steer_ff <= pwdata[7:0];
				cwg_pkg::SHUT_STATE_OFFSET: shst_ff <= pwdata[5:0];
				cwg_pkg::IRQ_MASK_OFFSET: mask_ff <= pwdata[1:0];
				default: ;
			endcase
		end
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_rd_done;
		acc && !pwrite;
	endsequence
	// Eight samples cover synchroniser, status and pin stages
	sequence s_src_hold;
		src_hit [*8];
	endsequence
	property p_ready;
		s_setup |=> pready;
	endproperty
	a_ready: assert property (p_ready)
		else $error("no ready after setup");
	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse)
		else $error("ready longer than one cycle");
	property p_slverr;
		acc |-> pslverr == (paddr[1:0] != 2'h0 || paddr > cwg_pkg::IRQ_MASK_OFFSET);
	endproperty
	a_slverr: assert property (p_slverr)
		else $error("error response wrong for address");
	property p_src_rd;
		s_rd_done ##0 paddr == cwg_pkg::SHUT_SOURCE_OFFSET |-> prdata == {27'h0, src_en_ff};
	endproperty
	a_src_rd: assert property (p_src_rd)
		else $error("source enable readback wrong");
	property p_steer_rd;
		s_rd_done ##0 paddr == cwg_pkg::STEER_OFFSET |-> prdata == {24'h0, steer_ff};
	endproperty
	a_steer_rd: assert property (p_steer_rd)
		else $error("steering readback wrong");
	property p_unimpl;
		s_rd_done |-> (paddr != cwg_pkg::CLK_SELECT_OFFSET || prdata[31:1] == 31'h0)
			&& (paddr != cwg_pkg::INPUT_SELECT_OFFSET || prdata[31:4] == 28'h0);
	endproperty
	a_unimpl: assert property (p_unimpl)
		else $error("unimplemented bits read nonzero");
	property p_shut;
		s_src_hold |-> waveform_oe_n[0] == (shst_ff[3:2] == cwg_pkg::SHUT_TRISTATE)
			&& (shst_ff[3:2] != cwg_pkg::SHUT_DRIVE_ZERO || !waveform_out[0])
			&& (shst_ff[5:4] != cwg_pkg::SHUT_DRIVE_ONE || waveform_out[1]);
	endproperty
	a_shut: assert property (p_shut)
		else $error("shutdown pin state wrong");
	property p_irq_mask;
		mask_ff == 2'h0 [*2] |-> !irq;
	endproperty
	a_irq_mask: assert property (p_irq_mask)
		else $error("interrupt while fully masked");
endmodule
bind waveform_gen_steering_select steering_select_chk steering_select_chk_inst (.pclk,
	.presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.logic_cell2_output, .comparator2_out, .comparator1_out, .timer2_postscale_out,
	.shutdown_pin_remap, .waveform_out, .waveform_oe_n, .irq);
`default_nettype wire

// ===== bench/bridge_driver_model.sv
// Purpose: far-side bridge driver inputs on the four outputs
// Assumes: no pull resistor on the lines
// Notes:   a released line shows the inverse of its last driven level
`timescale 1ns/1ps
`default_nettype none
module bridge_driver_model (
	input  wire logic       pclk,
	input  wire logic [3:0] drive_val,
	input  wire logic [3:0] drive_oe_n,
	output var  logic [3:0] pin_level
);
	logic [3:0] last_ff;
	// Remember what each line carried while driven
	always_ff @(posedge pclk) begin
		for (int i = 0; i < 4; i++) begin
			if (!drive_oe_n[i]) begin
				last_ff[i] <= drive_val[i];
			end
		end
	end
	// Floating line must not pass as a stale good value
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pin_level[i] = drive_oe_n[i] ? ~last_ff[i] : drive_val[i];
		end
	end
endmodule
`default_nettype wire

// ===== bench/test_waveform_gen_steering_select.sv
// Purpose: self-checking bench for the steering and select block
// Assumes: APB slave answers in the cycle after setup
// Notes:   driver queues expectations, monitors retire them
`timescale 1ns/1ps
`default_nettype none
module test_waveform_gen_steering_select;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [12:0] wsrc = 13'h0;
	logic [4:0]  sd = 5'h00;
	logic [3:0]  wout;
	logic [3:0]  woe_n;
	logic [3:0]  pins;
	logic        irq;
	logic        pin_stb = 1'b0;
	int          mismatches = 0;
	int          samples_checked = 0;
	logic [32:0] rd_q[$];
	logic [4:0]  pin_q[$];
	logic [7:0]  st;
	logic [3:0]  pol;
	logic [3:0]  e;
	logic        w;
	waveform_gen_steering_select waveform_gen_steering_select_inst (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .wave_sources(wsrc),
		.logic_cell2_output(sd[4]), .comparator2_out(sd[3]), .comparator1_out(sd[2]),
		.timer2_postscale_out(sd[1]), .shutdown_pin_remap(sd[0]), .waveform_out(wout),
		.waveform_oe_n(woe_n), .irq);
	bridge_driver_model bridge_driver_model_inst (.pclk, .drive_val(wout),
		.drive_oe_n(woe_n), .pin_level(pins));
	// 50 MHz
	always #10 pclk = ~pclk;
	task automatic give_verdict;
		if (mismatches == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic compare_val(input logic [32:0] seen, input logic [32:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Entered and left just after an edge, so no signal is set twice at once
	task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr_en;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] exp);
		rd_q.push_back(exp);
		apb(1'b0, a, 32'h0);
	endtask
	// Inputs pass synchronisers first, so settle before looking
	task automatic pins_are(input logic [4:0] exp);
		repeat (10) @(posedge pclk);
		pin_q.push_back(exp);
		pin_stb <= 1'b1;
		@(posedge pclk);
		pin_stb <= 1'b0;
	endtask
	// Each completed read or pin strobe retires the oldest note
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite)
			compare_val({pslverr, prdata}, rd_q.pop_front());
		if (pin_stb)
			compare_val({28'h0, irq, pins}, {28'h0, pin_q.pop_front()});
	end
	// Watchdog well beyond the fewer than a thousand cycles the run needs
	initial begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		give_verdict;
	end
	// Main sequence
	initial begin
		void'($urandom(32'hE18F));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(cwg_pkg::ENABLE_MODE_OFFSET, 33'h0);
		rd(cwg_pkg::SHUT_STATE_OFFSET, 33'h14);
		rd(cwg_pkg::STEER_OFFSET, 33'h0);
		rd(cwg_pkg::IRQ_MASK_OFFSET, 33'h0);
		wr(cwg_pkg::SHUT_SOURCE_OFFSET, 32'hFFFFFFFF);
		rd(cwg_pkg::SHUT_SOURCE_OFFSET, 33'h1F);
		wr(cwg_pkg::CLK_SELECT_OFFSET, 32'hFFFFFFFF);
		rd(cwg_pkg::CLK_SELECT_OFFSET, 33'h1);
		wr(cwg_pkg::INPUT_SELECT_OFFSET, 32'hFFFFFFFF);
		rd(cwg_pkg::INPUT_SELECT_OFFSET, 33'hF);
		wr(8'h2C, 32'hFF);
		rd(8'h2C, 33'h100000000);
		wr(cwg_pkg::SHUT_SOURCE_OFFSET, 32'h0);
		wr(cwg_pkg::CLK_SELECT_OFFSET, 32'h0);
		wr(cwg_pkg::INPUT_SELECT_OFFSET, 32'h1);
		wr(cwg_pkg::ENABLE_MODE_OFFSET, 32'h80);
		wr(cwg_pkg::IRQ_MASK_OFFSET, 32'h1);
		// Random steering, override and polarity mixes
		for (int i = 0; i < 8; i++) begin
			st = 8'($urandom);
			pol = 4'($urandom);
			w = 1'($urandom);
			wsrc[0] <= w;
			wr(cwg_pkg::POLARITY_OFFSET, {28'h0, pol});
			wr(cwg_pkg::STEER_OFFSET, {24'h0, st});
			rd(cwg_pkg::STEER_OFFSET, {25'h0, st});
			for (int b = 0; b < 4; b++) e[b] = st[b] ? w ^ pol[b] : st[4 + b];
			pins_are({1'b0, e});
		end
		// Input codes 1 to 15: one source high for codes 1..13, all high for 14 and 15
		wr(cwg_pkg::POLARITY_OFFSET, 32'h0);
		wr(cwg_pkg::STEER_OFFSET, 32'hF);
		for (int c = 1; c < 16; c++) begin
			wsrc <= (c < 14) ? 13'(13'h1 << (c - 1)) : 13'h1FFF;
			wr(cwg_pkg::INPUT_SELECT_OFFSET, 32'(c));
			pins_are({1'b0, {4{c < 14}}});
		end
		wsrc <= 13'h0;
		wr(cwg_pkg::INPUT_SELECT_OFFSET, 32'h1);
		wr(cwg_pkg::STEER_OFFSET, 32'hA0);
		pins_are(5'h0A);
		wr(cwg_pkg::ENABLE_MODE_OFFSET, 32'h81);
		wr(cwg_pkg::STEER_OFFSET, 32'hAF);
		pins_are(5'h0A);
		wsrc[0] <= 1'b1;
		pins_are(5'h0F);
		wr(cwg_pkg::ENABLE_MODE_OFFSET, 32'h86);
		pins_are(5'h00);
		wr(cwg_pkg::ENABLE_MODE_OFFSET, 32'h84);
		pins_are(5'h05);
		wr(cwg_pkg::ENABLE_MODE_OFFSET, 32'h80);
		wsrc[0] <= 1'b0;
		rd(cwg_pkg::IRQ_STATUS_OFFSET, 33'h2);
		// Each source ignored, then enabled, with two pair-state setups
		for (int k = 0; k < 5; k++) begin
			wr(cwg_pkg::SHUT_STATE_OFFSET, k[0] ? 32'h64 : 32'h78);
			sd <= 5'(5'h1 << k);
			pins_are(5'h00);
			wr(cwg_pkg::SHUT_SOURCE_OFFSET, 32'h1 << k);
			pins_are(k[0] ? 5'h15 : 5'h1A);
			sd <= 5'h00;
			pins_are(k[0] ? 5'h15 : 5'h1A);
			wsrc[0] <= 1'b1;
			pins_are(5'h1F);
			rd(cwg_pkg::IRQ_STATUS_OFFSET, 33'h3);
			wsrc[0] <= 1'b0;
			pins_are(5'h00);
		end
		give_verdict;
	end
endmodule
`default_nettype wire
